/* pkg/asp_defines.vh */
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// Register byte offsets
`define ASP_OFF_DATA 8'h00
`define ASP_OFF_CTRL 8'h04
`define ASP_OFF_DIV 8'h08
`define ASP_OFF_MASK 8'h0C
`define ASP_OFF_STAT 8'h10
`define ASP_OFF_ADDR 8'h14
// Control field positions
`define ASP_C_WLEN_LO 0
`define ASP_C_WLEN_HI 1
`define ASP_C_STOP2 2
`define ASP_C_PAREN 3
`define ASP_C_PAREVEN 4
`define ASP_C_NINE 5
`define ASP_C_TXDMA 6
`define ASP_C_RXDMA 7
`define ASP_C_AFILT 8
`define ASP_C_DMAHI 9
// Status field positions
`define ASP_S_RXRDY 0
`define ASP_S_THRE 1
`define ASP_S_TXIDLE 2
`define ASP_S_PERR 3
`define ASP_S_FERR 4
`define ASP_S_OERR 5
`define ASP_S_LISTEN 6
// Mask field positions
`define ASP_M_TX 0
`define ASP_M_RX 1
`define ASP_M_ERR 2
// Reset values
`define ASP_CTRL_RST 10'h003
`define ASP_DIV_RST 16'h0001
`define ASP_MASK_RST 3'h0
`define ASP_ADDR_RST 8'h00
// Oversampling: last phase of a bit, and the mid-bit phase
`define ASP_OS_LAST 4'hF
`define ASP_OS_MID 4'h7
`endif

/* rtl/asp_uart.v */
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "asp_defines.vh"
// Functional notes
// - Full-duplex transmit and receive, PC framing
// - Nine-bit mode, extra bit marks address
// - Five to eight data, stop, parity selectable
// - Frame spans seven to twelve bits
// - Holding plus shift register each direction
// - Separate transmit and receive DMA handshakes
// - DMA requests default to low priority
// - Rate clock over 16 to 1048576
// - Maskable transmit and receive interrupts
// - Parity, framing, overrun status readable
// - Synchronised receive line offered to timer
module asp_uart (
    // Clock and reset
    input wire clock,
    input wire srst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Serial link
    input wire rxd,
    output reg txd_q,
    // Transmit DMA
    output reg tx_dma_req_q,
    input wire tx_dma_ack,
    input wire [8:0] tx_dma_data,
    // Receive DMA
    output reg rx_dma_req_q,
    input wire rx_dma_ack,
    output wire [8:0] rx_dma_data,
    output reg dma_low_prio_q,
    // Interrupts and timer tap
    output reg irq_tx_q,
    output reg irq_rx_q,
    output reg rxd_timer_q
);
    localparam [4:0] S_IDLE = 5'h01, S_START = 5'h02, S_DATA = 5'h04;
    localparam [4:0] S_PAR = 5'h08, S_STOP = 5'h10;
    // Number of data bits including the ninth bit in nine-bit mode
    function [3:0] nbits;
        input [9:0] c;
        nbits = c[`ASP_C_NINE] ? 4'h9 : {2'h0, c[`ASP_C_WLEN_HI:`ASP_C_WLEN_LO]} + 4'h5;
    endfunction
    // Parity bit for the low n bits; parity is unused in nine-bit mode
    function par_bit;
        input [8:0] d;
        input [3:0] n;
        input even;
        integer i;
        reg x;
        begin
            x = 1'b0;
            for (i = 0; i < 9; i = i + 1)
                if (i < n)
                    x = x ^ d[i];
            par_bit = even ? x : ~x;
        end
    endfunction
    reg [9:0] ctrl_q;
    reg [15:0] div_q, os_cnt_q;
    reg [2:0] mask_q;
    reg [7:0] addr_q;
    reg [8:0] thr_q, tsh_q, rsh_q, rbr_q;
    reg [4:0] tst_q, rst_q;
    reg [3:0] tos_q, tbit_q, ros_q, rbit_q;
    reg thr_full_q, rxs1_q, rxs2_q, rpar_q;
    reg rx_ready_q, perr_q, ferr_q, oerr_q, listen_q;
    wire [3:0] nb = nbits(ctrl_q);
    wire use_par = ctrl_q[`ASP_C_PAREN] & ~ctrl_q[`ASP_C_NINE];
    wire tick = (os_cnt_q == 16'h0000);
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire rd_data = acc & ~pwrite & (paddr == `ASP_OFF_DATA);
    wire tx_idle = tst_q[0] & ~thr_full_q;
    wire [31:0] stat = {25'h0, listen_q, oerr_q, ferr_q, perr_q, tx_idle, ~thr_full_q, rx_ready_q};
    wire [2:0] err_clr = (wr && paddr == `ASP_OFF_STAT) ? pwdata[`ASP_S_OERR:`ASP_S_PERR] : 3'h0;
    assign rx_dma_data = rbr_q;
    // APB: one wait-free access phase, data latched at setup
    always @(posedge clock)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            case (paddr)
                `ASP_OFF_DATA: prdata <= {23'h0, rbr_q};
                `ASP_OFF_CTRL: prdata <= {22'h0, ctrl_q};
                `ASP_OFF_DIV: prdata <= {16'h0, div_q};
                `ASP_OFF_MASK: prdata <= {29'h0, mask_q};
                `ASP_OFF_STAT: prdata <= stat;
                `ASP_OFF_ADDR: prdata <= {24'h0, addr_q};
                default: pslverr <= psel & ~penable;
            endcase
        end
    end
    // Configuration registers
    always @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_q <= `ASP_CTRL_RST;
            div_q <= `ASP_DIV_RST;
            mask_q <= `ASP_MASK_RST;
            addr_q <= `ASP_ADDR_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `ASP_OFF_CTRL: ctrl_q <= pwdata[9:0];
                `ASP_OFF_DIV: div_q <= pwdata[15:0];
                `ASP_OFF_MASK: mask_q <= pwdata[2:0];
                `ASP_OFF_ADDR: addr_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // divisor tick, zero divides by 65536
    always @(posedge clock)
    begin
        if (srst)
            os_cnt_q <= 16'h0000;
        else if (tick)
            os_cnt_q <= div_q - 16'h0001;
        else
            os_cnt_q <= os_cnt_q - 16'h0001;
    end
    // transmitter; full holding register drops writes
    always @(posedge clock)
    begin
        if (srst)
        begin
            thr_full_q <= 1'b0;
            tst_q <= S_IDLE;
            txd_q <= 1'b1;
        end
        else
        begin
            if (tick)
            begin
                tos_q <= tos_q + 4'h1;
                case (tst_q)
                    S_IDLE:
                    begin
                        tos_q <= 4'h0;
                        txd_q <= 1'b1;
                        if (thr_full_q)
                        begin
                            tsh_q <= thr_q;
                            thr_full_q <= 1'b0;
                            txd_q <= 1'b0;
                            tst_q <= S_START;
                        end
                    end
                    S_START:
                        if (tos_q == `ASP_OS_LAST)
                        begin
                            txd_q <= tsh_q[0];
                            tbit_q <= 4'h0;
                            tst_q <= S_DATA;
                        end
                    S_DATA:
                        if (tos_q == `ASP_OS_LAST)
                        begin
                            tbit_q <= tbit_q + 4'h1;
                            txd_q <= tsh_q[tbit_q + 4'h1];
                            if (tbit_q == nb - 4'h1)
                            begin
                                txd_q <= use_par ? par_bit(tsh_q, nb,
                                    ctrl_q[`ASP_C_PAREVEN]) : 1'b1;
                                tbit_q <= 4'h0;
                                tst_q <= use_par ? S_PAR : S_STOP;
                            end
                        end
                    S_PAR:
                        if (tos_q == `ASP_OS_LAST)
                        begin
                            txd_q <= 1'b1;
                            tst_q <= S_STOP;
                        end
                    S_STOP:
                        if (tos_q == `ASP_OS_LAST)
                        begin
                            tbit_q <= tbit_q + 4'h1;
                            if (tbit_q[0] | ~ctrl_q[`ASP_C_STOP2])
                                tst_q <= S_IDLE;
                        end
                    default: tst_q <= S_IDLE;
                endcase
            end
            // DMA or processor fills holding register
            if (!thr_full_q && ctrl_q[`ASP_C_TXDMA] && tx_dma_ack)
            begin
                thr_q <= tx_dma_data;
                thr_full_q <= 1'b1;
            end
            else if (!thr_full_q && wr && paddr == `ASP_OFF_DATA)
            begin
                thr_q <= pwdata[8:0];
                thr_full_q <= 1'b1;
            end
        end
    end
    always @(posedge clock)
    begin
        if (srst)
        begin
            rxs1_q <= 1'b1;
            rxs2_q <= 1'b1;
            rst_q <= S_IDLE;
            rbr_q <= 9'h000;
            rx_ready_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            listen_q <= 1'b0;
        end
        else
        begin
            rxs1_q <= rxd;
            rxs2_q <= rxs1_q;
            // Clears first so that a same-cycle event still sets
            if (rd_data || (ctrl_q[`ASP_C_RXDMA] && rx_dma_ack))
                rx_ready_q <= 1'b0;
            perr_q <= perr_q & ~err_clr[0];
            ferr_q <= ferr_q & ~err_clr[1];
            oerr_q <= oerr_q & ~err_clr[2];
            if (tick)
            begin
                ros_q <= ros_q + 4'h1;
                case (rst_q)
                    S_IDLE:
                    begin
                        ros_q <= 4'h0;
                        if (!rxs2_q)
                            rst_q <= S_START;
                    end
                    S_START:
                        if (ros_q == `ASP_OS_MID)
                        begin
                            ros_q <= 4'h0;
                            rbit_q <= 4'h0;
                            rsh_q <= 9'h000;
                            rst_q <= rxs2_q ? S_IDLE : S_DATA;
                        end
                    S_DATA:
                        if (ros_q == `ASP_OS_LAST)
                        begin
                            rsh_q[rbit_q] <= rxs2_q;
                            rbit_q <= rbit_q + 4'h1;
                            if (rbit_q == nb - 4'h1)
                                rst_q <= use_par ? S_PAR : S_STOP;
                        end
                    S_PAR:
                        if (ros_q == `ASP_OS_LAST)
                        begin
                            rpar_q <= rxs2_q;
                            rst_q <= S_STOP;
                        end
                    S_STOP:
                        if (ros_q == `ASP_OS_LAST)
                        begin
                            rst_q <= S_IDLE;
                            if (!rxs2_q)
                                ferr_q <= 1'b1;
                            if (use_par && rpar_q != par_bit(rsh_q, nb,
                                ctrl_q[`ASP_C_PAREVEN]))
                                perr_q <= 1'b1;
                            if (ctrl_q[`ASP_C_NINE] && ctrl_q[`ASP_C_AFILT] && rsh_q[8])
                                listen_q <= (rsh_q[7:0] == addr_q);
                            if (!(ctrl_q[`ASP_C_NINE] && ctrl_q[`ASP_C_AFILT]) ||
                                (rsh_q[8] ? rsh_q[7:0] == addr_q : listen_q))
                            begin
                                if (rx_ready_q && !rd_data &&
                                    !(ctrl_q[`ASP_C_RXDMA] && rx_dma_ack))
                                    oerr_q <= 1'b1;
                                rbr_q <= rsh_q;
                                rx_ready_q <= 1'b1;
                            end
                        end
                    default: rst_q <= S_IDLE;
                endcase
            end
        end
    end
    // DMA requests, interrupts and timer tap
    always @(posedge clock)
    begin
        if (srst)
        begin
            tx_dma_req_q <= 1'b0;
            rx_dma_req_q <= 1'b0;
            dma_low_prio_q <= 1'b1;
            irq_tx_q <= 1'b0;
            irq_rx_q <= 1'b0;
            rxd_timer_q <= 1'b1;
        end
        else
        begin
            // request dropped at the acknowledging edge
            tx_dma_req_q <= ctrl_q[`ASP_C_TXDMA] & ~thr_full_q & ~tx_dma_ack;
            rx_dma_req_q <= ctrl_q[`ASP_C_RXDMA] & rx_ready_q & ~rx_dma_ack;
            dma_low_prio_q <= ~ctrl_q[`ASP_C_DMAHI];
            irq_tx_q <= mask_q[`ASP_M_TX] & ~thr_full_q;
            irq_rx_q <= (mask_q[`ASP_M_RX] & rx_ready_q) |
                (mask_q[`ASP_M_ERR] & (perr_q | ferr_q | oerr_q));
            // timer measures pulse widths on this
            rxd_timer_q <= rxs2_q;
        end
    end
endmodule

/* dv/asp_uart_properties.sv */
`timescale 1ns/100ps
`include "asp_defines.vh"
module asp_uart_props (
    // Clock and reset
    input logic clock,
    input logic srst,
    // Register bus
    input logic psel,
    input logic penable,
    input logic [7:0] paddr,
    input logic pready,
    input logic pslverr,
    // Serial link and timer tap
    input logic rxd,
    input logic txd_q,
    input logic rxd_timer_q,
    // DMA
    input logic tx_dma_req_q,
    input logic tx_dma_ack,
    input logic rx_dma_req_q,
    input logic rx_dma_ack,
    input logic dma_low_prio_q
);
    logic txd_last_q;
    int run_q;
    // Low stretches only occur inside frames, so their length must be whole bits
    always @(posedge clock)
    begin
        txd_last_q <= txd_q;
        if (srst || txd_q != txd_last_q)
            run_q <= 1;
        else
            run_q <= run_q + 1;
    end
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (srst);
    property p_ready_one; psel && !penable |=> pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready late");
    property p_map; pready |-> pslverr == !(paddr inside {`ASP_OFF_DATA, `ASP_OFF_CTRL,
        `ASP_OFF_DIV, `ASP_OFF_MASK, `ASP_OFF_STAT, `ASP_OFF_ADDR}); endproperty
    a_map: assert property (p_map) else $error("bad error response");
    property p_txd_run; txd_q && !txd_last_q |-> run_q % 16 == 0; endproperty
    a_txd_run: assert property (p_txd_run) else $error("bit not 16 ticks");
    property p_tx_drop; tx_dma_req_q && tx_dma_ack |=> !tx_dma_req_q; endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx request stuck");
    property p_rx_drop; rx_dma_req_q && rx_dma_ack |=> !rx_dma_req_q; endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx request stuck");
    property p_prio; $fell(srst) |-> dma_low_prio_q; endproperty
    a_prio: assert property (p_prio) else $error("priority not low");
    property p_idle; $fell(srst) |-> txd_q && !pready && !tx_dma_req_q && !rx_dma_req_q;
    endproperty
    a_idle: assert property (p_idle) else $error("not idle after reset");
    property p_tap; rxd_timer_q != $past(rxd_timer_q) |->
        rxd_timer_q == $past(rxd, 2) || rxd_timer_q == $past(rxd, 3); endproperty
    a_tap: assert property (p_tap) else $error("timer tap wrong");
endmodule
bind asp_uart asp_uart_props chk_u (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_q(txd_q),
    .rxd_timer_q(rxd_timer_q), .tx_dma_req_q(tx_dma_req_q), .tx_dma_ack(tx_dma_ack),
    .rx_dma_req_q(rx_dma_req_q), .rx_dma_ack(rx_dma_ack), .dma_low_prio_q(dma_low_prio_q));

/* dv/asp_link_model.sv */
`timescale 1ns/100ps
module asp_link_model (
    // Clock
    input logic clock,
    // Serial lines
    input logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // twelve-bit frames, start first; gap makes a late answer
    task automatic send(input logic [11:0] f, input int n, input int bt, input int gap);
        repeat (gap) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            rxd <= f[i];
            repeat (bt) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask
    // sample mid-bit from the falling start edge
    task automatic grab(output logic [11:0] f, input int n, input int bt);
        f = '1;
        @(negedge txd);
        repeat (bt / 2) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            f[i] = txd;
            repeat (bt) @(posedge clock);
        end
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/100ps
`include "asp_defines.vh"
module tb;
    typedef struct packed {logic [9:0] c; logic [8:0] ch; logic [3:0] dv;} asp_row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_dma_ack = 1'b0, rx_dma_ack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [8:0] tx_dma_data = 9'h000, rx_dma_data;
    logic pready, pslverr, err, rxd, txd_q, tx_dma_req_q, rx_dma_req_q, dma_low_prio_q;
    logic irq_tx_q, irq_rx_q, rxd_timer_q;
    logic [11:0] f, seen;
    int errors = 0, tests_run = 0, cycles = 0, n;
    asp_row_t rows [7] = '{'{10'h003, 9'h055, 4'h1}, '{10'h01C, 9'h013, 4'h1},
        '{10'h00A, 9'h05A, 4'h2}, '{10'h005, 9'h02A, 4'h1}, '{10'h000, 9'h011, 4'h1},
        '{10'h01F, 9'h0C3, 4'h1}, '{10'h023, 9'h1A5, 4'h1}};
    always #5 clock = ~clock;
    asp_uart dut_u (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .txd_q(txd_q), .tx_dma_req_q(tx_dma_req_q), .tx_dma_ack(tx_dma_ack),
        .tx_dma_data(tx_dma_data), .rx_dma_req_q(rx_dma_req_q), .rx_dma_ack(rx_dma_ack),
        .rx_dma_data(rx_dma_data), .dma_low_prio_q(dma_low_prio_q), .irq_tx_q(irq_tx_q),
        .irq_rx_q(irq_rx_q), .rxd_timer_q(rxd_timer_q));
    asp_link_model far_u (.clock(clock), .txd(txd_q), .rxd(rxd));
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Held until pready is seen, released only after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(q, e);
        check(err, ee);
    endtask
    // Expected line image: start, data LSB first, parity, stop bits
    function automatic int mk(input logic [9:0] c, input logic [8:0] ch, output logic [11:0] r);
        int k;
        int m;
        logic p;
        k = c[`ASP_C_NINE] ? 9 : 5 + c[1:0];
        p = ~c[`ASP_C_PAREVEN];
        r = '1;
        r[0] = 1'b0;
        for (int i = 0; i < k; i++)
        begin
            r[i + 1] = ch[i];
            p ^= ch[i];
        end
        m = k + 1;
        if (c[`ASP_C_PAREN] && !c[`ASP_C_NINE])
        begin
            r[m] = p;
            m++;
        end
        return m + (c[`ASP_C_STOP2] ? 2 : 1);
    endfunction
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check(txd_q, 1'b1);
        check(dma_low_prio_q, 1'b1);
        rdc(`ASP_OFF_CTRL, 32'h003, 1'b0);
        rdc(`ASP_OFF_STAT, 32'h006, 1'b0);
        rdc(8'h18, 32'h0, 1'b1);
        apb(1'b1, `ASP_OFF_DIV, 32'h10002);
        rdc(`ASP_OFF_DIV, 32'h0002, 1'b0);
        $display("test registers done");
        foreach (rows[i])
        begin
            apb(1'b1, `ASP_OFF_DIV, rows[i].dv);
            apb(1'b1, `ASP_OFF_CTRL, rows[i].c);
            n = mk(rows[i].c, rows[i].ch, f);
            fork
                far_u.grab(seen, n, 16 * rows[i].dv);
                far_u.send(f, n, 16 * rows[i].dv, 3);
                apb(1'b1, `ASP_OFF_DATA, rows[i].ch);
            join
            check(seen, f);
            rdc(`ASP_OFF_DATA, rows[i].ch, 1'b0);
            rdc(`ASP_OFF_STAT, 32'h006, 1'b0);
        end
        $display("test formats done");
        apb(1'b1, `ASP_OFF_DIV, 32'h1);
        apb(1'b1, `ASP_OFF_CTRL, 32'h01B);
        apb(1'b1, `ASP_OFF_MASK, 32'h4);
        n = mk(10'h01B, 9'h011, f);
        repeat (2) far_u.send(f, n, 16, 2);
        f[9] = ~f[9];
        far_u.send(f, n, 16, 2);
        f[9] = ~f[9];
        f[10] = 1'b0;
        far_u.send(f, n, 16, 2);
        rdc(`ASP_OFF_STAT, 32'h03F, 1'b0);
        check(irq_rx_q, 1'b1);
        apb(1'b1, `ASP_OFF_STAT, 32'h38);
        rdc(`ASP_OFF_DATA, 32'h011, 1'b0);
        rdc(`ASP_OFF_STAT, 32'h006, 1'b0);
        @(posedge clock);
        check(irq_rx_q, 1'b0);
        apb(1'b1, `ASP_OFF_MASK, 32'h1);
        @(posedge clock);
        check(irq_tx_q, 1'b1);
        apb(1'b1, `ASP_OFF_MASK, 32'h0);
        @(posedge clock);
        check(irq_tx_q, 1'b0);
        apb(1'b1, `ASP_OFF_ADDR, 32'h05A);
        apb(1'b1, `ASP_OFF_CTRL, 32'h123);
        n = mk(10'h123, 9'h011, f);
        far_u.send(f, n, 16, 2);
        n = mk(10'h123, 9'h15A, f);
        far_u.send(f, n, 16, 2);
        rdc(`ASP_OFF_STAT, 32'h047, 1'b0);
        rdc(`ASP_OFF_DATA, 32'h15A, 1'b0);
        n = mk(10'h123, 9'h033, f);
        far_u.send(f, n, 16, 2);
        rdc(`ASP_OFF_DATA, 32'h033, 1'b0);
        $display("test errors done");
        apb(1'b1, `ASP_OFF_CTRL, 32'h0C3);
        @(posedge clock);
        check(tx_dma_req_q, 1'b1);
        n = mk(10'h0C3, 9'h0A5, f);
        fork
            far_u.grab(seen, n, 16);
            begin
                tx_dma_data <= 9'h0A5;
                tx_dma_ack <= 1'b1;
                @(posedge clock);
                tx_dma_ack <= 1'b0;
            end
        join
        check(seen, f);
        n = mk(10'h0C3, 9'h03C, f);
        far_u.send(f, n, 16, 2);
        check(rx_dma_req_q, 1'b1);
        check(rx_dma_data, 9'h03C);
        rx_dma_ack <= 1'b1;
        @(posedge clock);
        rx_dma_ack <= 1'b0;
        repeat (2) @(posedge clock);
        check(rx_dma_req_q, 1'b0);
        apb(1'b1, `ASP_OFF_CTRL, 32'h203);
        @(posedge clock);
        check(dma_low_prio_q, 1'b0);
        $display("test dma done");
        apb(1'b1, `ASP_OFF_DATA, 32'h0);
        repeat (40) @(posedge clock);
        check(txd_q, 1'b0);
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check(txd_q, 1'b1);
        rdc(`ASP_OFF_CTRL, 32'h003, 1'b0);
        $display("test reset done");
        give_verdict;
    end
endmodule
